// ==== design/cbci_pkg.sv ====
// Package for the processor bus cycle interface: widths, status bits, states
package cbci_pkg;
  localparam int ADDR_W = 16;   // 64K byte locations
  localparam int DATA_W = 8;
  localparam int IO_W   = 8;    // 256 input and 256 output devices
  localparam int FIFO_DEPTH = 8;

  // Status word bit positions
  localparam int ST_INTA  = 0;
  localparam int ST_WO_N  = 1;
  localparam int ST_STACK = 2;
  localparam int ST_HLTA  = 3;
  localparam int ST_OUT   = 4;
  localparam int ST_M1    = 5;
  localparam int ST_INP   = 6;
  localparam int ST_MEMR  = 7;

  localparam logic [ADDR_W-1:0] PC_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [7:0] ZERO_HI = 8'h00;

  // Cycle kinds requested by the core
  typedef enum logic [2:0] {
    CBCI_FETCH = 3'h0,
    CBCI_MRD   = 3'h1,
    CBCI_MWR   = 3'h2,
    CBCI_IN    = 3'h3,
    CBCI_OUT   = 3'h4,
    CBCI_HALT  = 3'h5
  } cbci_kind_t;

  // One bus request from the core, carried through the FIFO
  typedef struct packed {
    cbci_kind_t          kind;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
  } cbci_req_t;

  localparam int REQ_W = $bits(cbci_req_t);

  // Bus states, one-hot
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_T1   = 6'h02,
    S_T2   = 6'h04,
    S_TW   = 6'h08,
    S_T3   = 6'h10,
    S_HOLD = 6'h20
  } cbci_state_t;
endpackage

// ==== design/cbci_fifo.sv ====
// Request FIFO with parameterised width and depth
`timescale 1ns/10ps
module cbci_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             CLK,
  input  wire logic             RESET_N,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
  localparam logic [PW:0] ONE_C   = (PW+1)'(1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [PW:0]      cnt_q;
  wire              push;
  wire              pop;

  // Honest flags straight from the fill count
  assign in_ready  = (cnt_q != DEPTH_C);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage has no reset; only pointers and the count need a defined value
  always_ff @(posedge CLK)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

  // Pointers wrap since depth is a power of two
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + PW'(1);
      if (pop)
        rd_q <= rd_q + PW'(1);
      if (push && !pop)
        cnt_q <= cnt_q + ONE_C;
      else if (pop && !push)
        cnt_q <= cnt_q - ONE_C;
    end
  end
endmodule

// ==== design/cbci_top.sv ====
// Processor external bus cycle engine: status, wait, hold and strobes
`timescale 1ns/10ps
module cbci_top (
  input  wire logic                         CLK,
  input  wire logic                         RESET_N,
  // Request stream from the core
  input  wire logic                         REQ_VALID,
  output logic                              REQ_READY,
  input  wire cbci_pkg::cbci_req_t          REQ_DATA,
  // Read data back to the core
  output logic                              RD_VALID,
  output logic [cbci_pkg::DATA_W-1:0]       RD_DATA,
  // Program counter seen by the core, cleared by reset
  output logic [cbci_pkg::ADDR_W-1:0]       PC,
  // External bus
  output logic [cbci_pkg::ADDR_W-1:0]       ADDR_O,
  output logic                              ADDR_OE_N,
  input  wire logic [cbci_pkg::DATA_W-1:0]  DATA_I,
  output logic [cbci_pkg::DATA_W-1:0]       DATA_O,
  output logic                              DATA_OE_N,
  output logic                              SYNC_O,
  output logic                              DATA_IN_WINDOW,
  input  wire logic                         READY,
  output logic                              WAIT_ACK,
  output logic                              WR_N,
  input  wire logic                         HOLD,
  output logic                              HOLD_GRANT
);
  cbci_pkg::cbci_state_t state_q;
  cbci_pkg::cbci_state_t state_d;
  cbci_pkg::cbci_req_t   cur_q;
  cbci_pkg::cbci_req_t   fifo_data;
  logic                  fifo_valid;
  logic                  fifo_pop;
  logic                  hold_armed_q;
  logic                  halted_q;
  logic                  wr_late_q;
  logic [cbci_pkg::ADDR_W-1:0] pc_q;
  logic [cbci_pkg::DATA_W-1:0] rdata_q;
  logic                  rd_valid_q;
  logic [cbci_pkg::DATA_W-1:0] status_w;

  cbci_fifo #(
    .WIDTH (cbci_pkg::REQ_W),
    .DEPTH (cbci_pkg::FIFO_DEPTH)
  ) u_fifo (
    .CLK       (CLK),
    .RESET_N   (RESET_N),
    .in_valid  (REQ_VALID),
    .in_ready  (REQ_READY),
    .in_data   (REQ_DATA),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // Decode of the bus state and the current cycle kind
  wire in_t1   = (state_q == cbci_pkg::S_T1);
  wire in_t2   = (state_q == cbci_pkg::S_T2);
  wire in_tw   = (state_q == cbci_pkg::S_TW);
  wire in_t3   = (state_q == cbci_pkg::S_T3);
  wire in_hold = (state_q == cbci_pkg::S_HOLD);
  wire k_write = (cur_q.kind == cbci_pkg::CBCI_MWR) || (cur_q.kind == cbci_pkg::CBCI_OUT);
  wire k_io    = (cur_q.kind == cbci_pkg::CBCI_IN) || (cur_q.kind == cbci_pkg::CBCI_OUT);
  wire k_halt  = (cur_q.kind == cbci_pkg::CBCI_HALT);
  wire k_read  = !k_write && !k_halt;
  // Hold may only be taken at these points
  wire hold_ok = HOLD && (halted_q || ((in_t2 || in_tw) && READY));
  // Idle enters hold when halted, or one period after a write's T3
  wire hold_enter = hold_armed_q && (halted_q || wr_late_q);
  // The engine may pop a new request only from idle; stalls back-pressure the FIFO
  // Never pop while entering hold, or the popped request would be lost
  assign fifo_pop = (state_q == cbci_pkg::S_IDLE) && !HOLD && !halted_q && !hold_enter;

  // Status word bits for the cycle in T1
  always_comb
  begin
    status_w = cbci_pkg::DATA_ZERO;
    status_w[cbci_pkg::ST_WO_N] = !k_write;
    status_w[cbci_pkg::ST_M1]   = (cur_q.kind == cbci_pkg::CBCI_FETCH);
    status_w[cbci_pkg::ST_MEMR] = (cur_q.kind == cbci_pkg::CBCI_FETCH) ||
                                  (cur_q.kind == cbci_pkg::CBCI_MRD);
    status_w[cbci_pkg::ST_INP]  = (cur_q.kind == cbci_pkg::CBCI_IN);
    status_w[cbci_pkg::ST_OUT]  = (cur_q.kind == cbci_pkg::CBCI_OUT);
    status_w[cbci_pkg::ST_HLTA] = k_halt;
  end

  // Next state: T1 then T2, wait while ready low, T3, optional hold
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      cbci_pkg::S_IDLE: if (hold_enter) state_d = cbci_pkg::S_HOLD;
                        else if (fifo_valid && fifo_pop) state_d = cbci_pkg::S_T1;
      cbci_pkg::S_T1:   state_d = cbci_pkg::S_T2;
      cbci_pkg::S_T2,
      cbci_pkg::S_TW:   state_d = READY ? cbci_pkg::S_T3 : cbci_pkg::S_TW;
      cbci_pkg::S_T3:   state_d = (hold_armed_q && !k_write) ? cbci_pkg::S_HOLD
                                                             : cbci_pkg::S_IDLE;
      cbci_pkg::S_HOLD: state_d = HOLD ? cbci_pkg::S_HOLD : cbci_pkg::S_IDLE;
    endcase
  end

  // State, captured request and hold bookkeeping
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      state_q      <= cbci_pkg::S_IDLE;
      cur_q        <= '0;
      hold_armed_q <= 1'b0;
      halted_q     <= 1'b0;
      wr_late_q    <= 1'b0;
      pc_q         <= cbci_pkg::PC_RESET;
    end
    else
    begin
      state_q <= state_d;
      if (fifo_valid && fifo_pop)
        cur_q <= fifo_data;
      if (hold_ok)
        hold_armed_q <= 1'b1;
      else if (in_hold && !HOLD)
        hold_armed_q <= 1'b0;
      if (in_t3 && k_halt)
        halted_q <= 1'b1;
      wr_late_q <= in_t3 && k_write && hold_armed_q;
      if (in_t3 && (cur_q.kind == cbci_pkg::CBCI_FETCH))
        pc_q <= cur_q.addr + cbci_pkg::ADDR_W'(1);
    end
  end

  // Read data capture at the end of T3
  always_ff @(posedge CLK)
  begin
    if (!RESET_N)
    begin
      rdata_q    <= cbci_pkg::DATA_ZERO;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= in_t3 && k_read;
      if (in_t3 && k_read)
        rdata_q <= DATA_I;
    end
  end

  // Bus outputs; I/O puts device number on both halves of the address
  wire cyc = in_t1 || in_t2 || in_tw || in_t3;
  assign ADDR_O    = k_io ? {cur_q.addr[cbci_pkg::IO_W-1:0], cur_q.addr[cbci_pkg::IO_W-1:0]}
                          : cur_q.addr;
  assign ADDR_OE_N = !cyc;
  assign DATA_O    = in_t1 ? status_w : cur_q.wdata;
  assign DATA_OE_N = !(in_t1 || (k_write && !in_t1 && cyc));
  assign SYNC_O    = in_t1;
  assign DATA_IN_WINDOW = k_read && (in_t2 || in_tw || in_t3);
  assign WAIT_ACK  = in_tw;
  // Strobe only in T3, where data has stood since T2
  assign WR_N      = !(k_write && in_t3);
  assign HOLD_GRANT = in_hold;
  assign RD_VALID  = rd_valid_q;
  assign RD_DATA   = rdata_q;
  assign PC        = pc_q;

  // Status only in the marker cycle
  property p_status;
    @(posedge CLK) disable iff (!RESET_N)
    SYNC_O |-> (!DATA_OE_N && DATA_O == status_w) ##1 !SYNC_O;
  endproperty
  a_status: assert property (p_status) else $error("status missing in T1");

  property p_wait;
    @(posedge CLK) disable iff (!RESET_N)
    ((in_t2 || in_tw) && !READY) |=> WAIT_ACK;
  endproperty
  a_wait: assert property (p_wait) else $error("no wait on low ready");

  property p_wack;
    @(posedge CLK) disable iff (!RESET_N)
    WAIT_ACK |-> (state_q == cbci_pkg::S_TW);
  endproperty
  a_wack: assert property (p_wack) else $error("wait ack outside wait");

  property p_float;
    @(posedge CLK) disable iff (!RESET_N)
    HOLD_GRANT |-> (ADDR_OE_N && DATA_OE_N);
  endproperty
  a_float: assert property (p_float) else $error("bus driven in hold");

  property p_wr_stable;
    @(posedge CLK) disable iff (!RESET_N)
    !WR_N |-> (!DATA_OE_N && DATA_O == cur_q.wdata && $stable(DATA_O));
  endproperty
  a_wr_stable: assert property (p_wr_stable) else $error("write data moved");

  property p_data_in_window;
    @(posedge CLK) disable iff (!RESET_N)
    DATA_IN_WINDOW |-> DATA_OE_N;
  endproperty
  a_data_in_window: assert property (p_data_in_window) else $error("driving in input window");

  property p_sync_seq;
    @(posedge CLK) disable iff (!RESET_N)
    SYNC_O |=> in_t2;
  endproperty
  a_sync_seq: assert property (p_sync_seq) else $error("T2 does not follow T1");

  property p_hold_rd;
    @(posedge CLK) disable iff (!RESET_N)
    (in_t3 && hold_armed_q && k_read) |=> HOLD_GRANT;
  endproperty
  a_hold_rd: assert property (p_hold_rd) else $error("read hold grant late");

  // Writes keep the bus one period longer than reads before the grant
  property p_hold_wr;
    @(posedge CLK) disable iff (!RESET_N)
    (in_t3 && hold_armed_q && k_write) |=> !HOLD_GRANT ##1 HOLD_GRANT;
  endproperty
  a_hold_wr: assert property (p_hold_wr) else $error("write hold grant mistimed");
endmodule

// ==== tb/cbci_mem_model.sv ====
// Memory and I/O partner with programmable wait states
`timescale 1ns/10ps
module cbci_mem_model (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        SYNC_O,
  input  wire logic [15:0] ADDR_O,
  input  wire logic [7:0]  DATA_O,
  input  wire logic        DATA_IN_WINDOW,
  input  wire logic        WR_N,
  input  wire logic [3:0]  WAIT_N,
  output logic             READY,
  output logic [7:0]       DATA_I
);
  logic [7:0] mem [256];
  logic [3:0] cnt_q;
  logic [7:0] last_q;
  // Count saturates so a slow device still ends its access
  always_ff @(posedge CLK)
  begin
    cnt_q  <= !RESET_N || SYNC_O ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hF};
    last_q <= !RESET_N ? 8'h00 : DATA_I;
    if (!WR_N)
      mem[ADDR_O[7:0]] <= DATA_O;
  end
  // Ready held low until the access time has run
  assign READY  = cnt_q >= WAIT_N;
  // Data only inside the window, else a changing pattern
  assign DATA_I = DATA_IN_WINDOW ? mem[ADDR_O[7:0]] : ~last_q;
endmodule

// ==== tb/cbci_top_tb.sv ====
// Self-checking bench for the bus cycle engine
`timescale 1ns/10ps
module cbci_top_tb;
  logic CLK, RESET_N, REQ_VALID, REQ_READY, RD_VALID, ADDR_OE_N, DATA_OE_N;
  logic SYNC_O, DATA_IN_WINDOW, READY, WAIT_ACK, WR_N, HOLD, HOLD_GRANT;
  logic [15:0] PC, ADDR_O;
  logic [7:0] RD_DATA, DATA_I, DATA_O, rd;
  logic [3:0] wait_n;
  logic hold_t1;
  cbci_pkg::cbci_req_t REQ_DATA;
  int miscompares, n_compared, nw, nd;

  cbci_top dut (.CLK(CLK), .RESET_N(RESET_N), .REQ_VALID(REQ_VALID),
    .REQ_READY(REQ_READY), .REQ_DATA(REQ_DATA), .RD_VALID(RD_VALID),
    .RD_DATA(RD_DATA), .PC(PC), .ADDR_O(ADDR_O), .ADDR_OE_N(ADDR_OE_N),
    .DATA_I(DATA_I), .DATA_O(DATA_O), .DATA_OE_N(DATA_OE_N), .SYNC_O(SYNC_O),
    .DATA_IN_WINDOW(DATA_IN_WINDOW), .READY(READY), .WAIT_ACK(WAIT_ACK),
    .WR_N(WR_N), .HOLD(HOLD), .HOLD_GRANT(HOLD_GRANT));
  cbci_mem_model mem (.CLK(CLK), .RESET_N(RESET_N), .SYNC_O(SYNC_O),
    .ADDR_O(ADDR_O), .DATA_O(DATA_O), .DATA_IN_WINDOW(DATA_IN_WINDOW),
    .WR_N(WR_N), .WAIT_N(wait_n), .READY(READY), .DATA_I(DATA_I));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One bus cycle: queue it, find the marker, follow it to its end
  task automatic run(input cbci_pkg::cbci_kind_t k, input logic [15:0] a,
                     input logic [7:0] w, input logic [7:0] st, input logic [15:0] ea);
    int i;
    i = 0;
    nw = 0;
    nd = 0;
    REQ_VALID = 1'b1;
    REQ_DATA = '{k, a, w};
    // Ready is judged settled at the falling edge, then one rising edge takes it
    while (REQ_READY !== 1'b1)
      @(negedge CLK);
    @(negedge CLK);
    REQ_VALID = 1'b0;
    while (SYNC_O !== 1'b1 && i < 20)
    begin
      @(negedge CLK);
      i++;
    end
    // Hold raised in T1: the cycle has started, so T2 can accept it
    if (hold_t1)
      HOLD = 1'b1;
    chk(SYNC_O, 1'b1);
    chk(DATA_O, st);
    chk(DATA_OE_N, 1'b0);
    chk(ADDR_O, ea);
    for (i = 0; i < 30; i++)
    begin
      @(negedge CLK);
      nw += WAIT_ACK;
      nd += DATA_IN_WINDOW;
      if (DATA_IN_WINDOW === 1'b1)
        chk(DATA_OE_N, 1'b1);
      if (RD_VALID === 1'b1 || WR_N === 1'b0 || (k == cbci_pkg::CBCI_HALT && i == 2))
        break;
    end
    rd = RD_DATA;
    if (WR_N === 1'b0)
      chk(DATA_O, w);
  endtask

  task automatic t_basic();
    run(cbci_pkg::CBCI_MWR, 16'h0012, 8'hA5, 8'h00, 16'h0012);
    run(cbci_pkg::CBCI_MRD, 16'h0012, 8'h00, 8'h82, 16'h0012);
    chk(rd, 8'hA5);
    chk(nw[15:0], 16'h0000);
    run(cbci_pkg::CBCI_FETCH, 16'h0012, 8'h00, 8'hA2, 16'h0012);
    chk(PC, 16'h0013);
    run(cbci_pkg::CBCI_OUT, 16'h005C, 8'h3C, 8'h10, 16'h5C5C);
    run(cbci_pkg::CBCI_IN, 16'h005C, 8'h00, 8'h42, 16'h5C5C);
    chk(rd, 8'h3C);
    $display("test basic done");
  endtask

  // Slow device: three wait cycles, window stays open
  task automatic t_wait();
    wait_n = 4'h3;
    run(cbci_pkg::CBCI_MRD, 16'h0012, 8'h00, 8'h82, 16'h0012);
    chk(nw[15:0], 16'h0003);
    chk(nd[15:0], 16'h0005);
    chk(rd, 8'hA5);
    wait_n = 4'h0;
    $display("test wait done");
  endtask

  task automatic t_hold();
    int s;
    s = 0;
    hold_t1 = 1'b1;
    run(cbci_pkg::CBCI_MRD, 16'h0012, 8'h00, 8'h82, 16'h0012);
    chk(HOLD_GRANT, 1'b1);
    chk(ADDR_OE_N, 1'b1);
    HOLD = 1'b0;
    repeat (3) @(negedge CLK);
    run(cbci_pkg::CBCI_MWR, 16'h0013, 8'h5A, 8'h00, 16'h0013);
    chk(HOLD_GRANT, 1'b0);
    @(negedge CLK);
    chk(HOLD_GRANT, 1'b0);
    @(negedge CLK);
    chk(HOLD_GRANT, 1'b1);
    chk(DATA_OE_N, 1'b1);
    hold_t1 = 1'b0;
    // Queued work must wait until the bus is handed back
    REQ_VALID = 1'b1;
    repeat (6) @(negedge CLK);
    REQ_VALID = 1'b0;
    chk(SYNC_O, 1'b0);
    HOLD = 1'b0;
    // Six queued writes of four periods each drain well inside this span
    repeat (30)
    begin
      @(negedge CLK);
      s += SYNC_O;
    end
    chk(s[15:0], 16'h0006);
    $display("test hold done");
  endtask

  // Slow first cycle lets the queue fill, then it drains
  task automatic t_fifo();
    int n, s;
    n = 0;
    s = 0;
    wait_n = 4'hF;
    REQ_VALID = 1'b1;
    REQ_DATA = '{cbci_pkg::CBCI_MRD, 16'h0012, 8'h00};
    // Ready counted where settled; the first cycle's marker falls in here too
    repeat (12)
    begin
      n += REQ_READY;
      s += SYNC_O;
      @(negedge CLK);
    end
    REQ_VALID = 1'b0;
    chk(REQ_READY, 1'b0);
    chk(n[15:0], 16'(cbci_pkg::FIFO_DEPTH + 1));
    wait_n = 4'h0;
    repeat (120)
    begin
      @(negedge CLK);
      s += SYNC_O;
    end
    chk(s[15:0], n[15:0]);
    $display("test fifo done");
  endtask

  task automatic t_halt();
    run(cbci_pkg::CBCI_HALT, 16'h0014, 8'h00, 8'h0A, 16'h0014);
    HOLD = 1'b1;
    repeat (3) @(negedge CLK);
    chk(HOLD_GRANT, 1'b1);
    HOLD = 1'b0;
    RESET_N = 1'b0;
    repeat (2) @(negedge CLK);
    RESET_N = 1'b1;
    chk(PC, 16'h0000);
    chk(HOLD_GRANT, 1'b0);
    // Only reset leaves halt; the bus must run again straight after it
    run(cbci_pkg::CBCI_MRD, 16'h0012, 8'h00, 8'h82, 16'h0012);
    chk(rd, 8'hA5);
    $display("test halt done");
  endtask

  initial
  begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // Whole run is a few hundred cycles
  initial
  begin
    #100000;
    miscompares++;
    finish_test();
  end

  initial
  begin
    RESET_N = 1'b0;
    REQ_VALID = 1'b0;
    REQ_DATA = '0;
    HOLD = 1'b0;
    wait_n = 4'h0;
    hold_t1 = 1'b0;
    miscompares = 0;
    n_compared = 0;
    repeat (10) @(negedge CLK);
    RESET_N = 1'b1;
    chk({ADDR_OE_N, DATA_OE_N, SYNC_O, WR_N, HOLD_GRANT}, 16'h001A);
    chk(PC, 16'h0000);
    t_basic();
    t_wait();
    t_hold();
    t_fifo();
    t_halt();
    finish_test();
  end
endmodule
